// ==== fxr_pkg.sv ====
// Package: constants and types for the extended read-parameter register block
package fxr_pkg;
    // Register layout
    localparam int REG_W = 8;
    localparam int DRV_MSB = 7;
    localparam int DRV_LSB = 5;
    localparam int DRV_W = 3;
    localparam int RSV_BIT = 4;
    localparam int ERASE_ERR_BIT = 3;
    localparam int PROG_ERR_BIT = 2;
    localparam int PROT_ERR_BIT = 1;
    localparam int BUSY_BIT = 0;
    // Reserved bit reads as one
    localparam logic RSV_VALUE = 1'b1;
    // Drive strength default code (50 %)
    localparam logic [2:0] DRV_DEFAULT = 3'h7;
    // Opcodes
    localparam logic [7:0] OP_SET_NV = 8'h85;
    localparam logic [7:0] OP_SET_V = 8'h83;
    localparam logic [7:0] OP_CLEAR = 8'h82;
    // Drive strength in eighths of full strength
    localparam logic [3:0] STR_RSVD = 4'h0;
    localparam logic [3:0] STR_12P5 = 4'h1;
    localparam logic [3:0] STR_25 = 4'h2;
    localparam logic [3:0] STR_37P5 = 4'h3;
    localparam logic [3:0] STR_50 = 4'h4;
    localparam logic [3:0] STR_75 = 4'h6;
    localparam logic [3:0] STR_100 = 4'h8;
    // Operation kinds reported by the array engines
    typedef enum logic [2:0] {
        FXR_OP_PAGE_PROG,
        FXR_OP_INFO_PROG,
        FXR_OP_ARRAY_ERASE,
        FXR_OP_CHIP_ERASE,
        FXR_OP_NV_REG_UPDATE,
        FXR_OP_FUNC_WRITE,
        FXR_OP_STATUS_WRITE
    } fxr_op_t;
endpackage

// ==== fxr_sync.sv ====
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module fxr_sync (
    input wire logic clk, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } fxr_sync_st_t;
    fxr_sync_st_t st, next_st;
    // First stage feeds only the second
    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign dout = st.s2;
endmodule // fxr_sync

// ==== fxr_drive_decode.sv ====
// Drive strength code to strength level decoder
`timescale 1ns/1ns
module fxr_drive_decode
    import fxr_pkg::*;
(
    input wire logic [fxr_pkg::DRV_W-1:0] code, // Drive field
    output logic [3:0] eighths, // Strength in eighths
    output logic reserved // Code is reserved
);
    // Table lookup; reserved codes give zero strength
    always_comb begin
        reserved = 1'b0;
        case (code)
            3'h1: eighths = STR_12P5;
            3'h2: eighths = STR_25;
            3'h3: eighths = STR_37P5;
            3'h5: eighths = STR_75;
            3'h6: eighths = STR_100;
            3'h7: eighths = STR_50;
            default: begin
                eighths = STR_RSVD;
                reserved = 1'b1;
            end
        endcase
    end
endmodule // fxr_drive_decode

// ==== fxr_ext_reg.sv ====
// Extended read-parameter register: drive strength copies, busy mirror, sticky error flags
`timescale 1ns/1ns
module fxr_ext_reg
    import fxr_pkg::*;
(
    input wire logic clk, // Clock, 20 MHz
    input wire logic arst_n, // Async hardware reset, active low
    input wire logic soft_reset, // Software reset pulse
    input wire logic cmd_valid, // Decoded command pulse
    input wire logic [7:0] cmd_opcode, // Decoded opcode
    input wire logic [fxr_pkg::REG_W-1:0] cmd_data, // Data byte of the command
    input wire logic op_in_progress, // Status register busy bit
    input wire logic op_done, // Array or register operation finished pulse
    input wire fxr_pkg::fxr_op_t op_kind, // Kind of finished operation
    input wire logic op_fail, // Operation failed
    input wire logic op_erase_phase_fail, // NV update erase phase failed
    input wire logic op_prog_phase_fail, // NV update program phase failed
    input wire logic op_target_protected, // Target protected, locked or suspended
    input wire logic [3:0] block_protect_bits, // Block protection bits
    input wire logic status_write_lock, // Status write lock bit
    input wire logic wp_n_pin, // Write-protect pin, asynchronous
    output logic [fxr_pkg::REG_W-1:0] read_param_ext_status, // Register read value
    output logic [fxr_pkg::DRV_W-1:0] drive_strength, // Working drive code
    output logic [3:0] drive_eighths, // Decoded strength in eighths
    output logic drive_code_reserved, // Working code is reserved
    output logic chip_erase_reject // Chip erase refused, one cycle pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [DRV_W-1:0] drv_nv;
        logic [DRV_W-1:0] drv_v;
        logic busy;
        logic prot_err;
        logic prog_err;
        logic erase_err;
        logic ce_rej;
        logic [3:0] eighths;
        logic rsvd;
        logic loaded;
    } fxr_st_t;

    fxr_st_t st, next_st;
    logic wp_n_sync;
    logic [3:0] dec_eighths;
    logic dec_rsvd;
    logic set_prot, set_prog, set_erase;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and decoder
    fxr_sync u_wp_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(wp_n_pin),
        .dout(wp_n_sync)
    );

    fxr_drive_decode u_dec (
        .code(next_st.drv_v),
        .eighths(dec_eighths),
        .reserved(dec_rsvd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Error event classification from finished operations
    always_comb begin
        set_prot = 1'b0;
        set_prog = 1'b0;
        set_erase = 1'b0;
        if (op_done) begin
            case (op_kind)
                FXR_OP_PAGE_PROG, FXR_OP_INFO_PROG: begin
                    // Protected, locked or suspended target fails the program
                    set_prog = op_fail | op_target_protected;
                    set_prot = op_target_protected;
                end
                FXR_OP_ARRAY_ERASE: begin
                    set_erase = op_fail | op_target_protected;
                    set_prot = op_target_protected;
                end
                FXR_OP_CHIP_ERASE: begin
                    // Any nonzero block-protect bit refuses the chip erase
                    set_erase = op_fail | op_target_protected | (|block_protect_bits);
                    set_prot = op_target_protected | (|block_protect_bits);
                end
                FXR_OP_NV_REG_UPDATE: begin
                    set_erase = op_erase_phase_fail;
                    set_prog = op_prog_phase_fail;
                end
                FXR_OP_FUNC_WRITE: begin
                    // OTP clear attempts never reach here as failures
                    set_prog = op_fail;
                end
                FXR_OP_STATUS_WRITE: begin
                    // Locked only when lock bit set and pin low
                    if (status_write_lock && !wp_n_sync) begin
                        set_prot = 1'b1;
                        set_erase = 1'b1;
                    end else begin
                        set_erase = op_erase_phase_fail;
                        set_prog = op_prog_phase_fail;
                    end
                end
                default: begin
                    set_prot = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        next_st.busy = op_in_progress;
        next_st.ce_rej = op_done && (op_kind == FXR_OP_CHIP_ERASE) && (|block_protect_bits);
        // First cycle after reset copies the NV setting into the working copy
        if (!st.loaded) begin
            next_st.drv_v = st.drv_nv;
            next_st.loaded = 1'b1;
        end
        // Set commands touch only the drive field of the chosen copy
        if (cmd_valid && cmd_opcode == OP_SET_NV) begin
            next_st.drv_nv = cmd_data[DRV_MSB:DRV_LSB];
        end
        if (cmd_valid && cmd_opcode == OP_SET_V) begin
            next_st.drv_v = cmd_data[DRV_MSB:DRV_LSB];
        end
        // Clear and soft reset drop only the flags; a same-cycle event still sets
        if ((cmd_valid && cmd_opcode == OP_CLEAR) || soft_reset) begin
            next_st.prot_err = 1'b0;
            next_st.prog_err = 1'b0;
            next_st.erase_err = 1'b0;
        end
        // Flags are sticky; commands keep running regardless
        next_st.prot_err = next_st.prot_err | set_prot;
        next_st.prog_err = next_st.prog_err | set_prog;
        next_st.erase_err = next_st.erase_err | set_erase;
        next_st.eighths = dec_eighths;
        next_st.rsvd = dec_rsvd;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; NV copy keeps its stored value across reset in the real array,
    // here it resets to the factory default.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.drv_nv <= DRV_DEFAULT;
            st.drv_v <= DRV_DEFAULT;
            st.busy <= 1'b0;
            st.prot_err <= 1'b0;
            st.prog_err <= 1'b0;
            st.erase_err <= 1'b0;
            st.ce_rej <= 1'b0;
            st.eighths <= STR_50;
            st.rsvd <= 1'b0;
            st.loaded <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    always_comb begin
        read_param_ext_status = '0;
        read_param_ext_status[DRV_MSB:DRV_LSB] = st.drv_v;
        read_param_ext_status[RSV_BIT] = RSV_VALUE;
        read_param_ext_status[ERASE_ERR_BIT] = st.erase_err;
        read_param_ext_status[PROG_ERR_BIT] = st.prog_err;
        read_param_ext_status[PROT_ERR_BIT] = st.prot_err;
        read_param_ext_status[BUSY_BIT] = st.busy;
    end
    assign drive_strength = st.drv_v;
    assign drive_eighths = st.eighths;
    assign drive_code_reserved = st.rsvd;
    assign chip_erase_reject = st.ce_rej;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    busy_mirror_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 read_param_ext_status[BUSY_BIT] == $past(op_in_progress))
        else $error("busy bit does not mirror status busy");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.prog_err && !(cmd_valid && cmd_opcode == OP_CLEAR) && !soft_reset) |=> st.prog_err)
        else $error("program flag dropped without clear");
    clear_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_CLEAR && !op_done) |=> !st.prot_err && !st.prog_err && !st.erase_err)
        else $error("clear did not drop flags");
    clear_keeps_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.loaded && cmd_valid && cmd_opcode == OP_CLEAR) |=> $stable(st.drv_v))
        else $error("clear changed drive field");
    set_v_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_SET_V) |=> drive_strength == $past(cmd_data[DRV_MSB:DRV_LSB]))
        else $error("volatile copy not written");
    set_nv_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.loaded && cmd_valid && cmd_opcode == OP_SET_NV) |=> $stable(st.drv_v))
        else $error("NV set touched working copy");
    status_bits_ro_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && !op_done && cmd_opcode == OP_SET_V && !st.busy && !op_in_progress) |=>
        $stable(read_param_ext_status[ERASE_ERR_BIT:PROT_ERR_BIT]))
        else $error("set command changed status bits");
    reserved_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
        read_param_ext_status[RSV_BIT] == RSV_VALUE)
        else $error("reserved bit changed");
    chip_erase_prot_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_CHIP_ERASE && |block_protect_bits) |=> st.erase_err && st.prot_err && chip_erase_reject)
        else $error("chip erase with block protect not flagged");
    prog_protect_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_PAGE_PROG && op_target_protected) |=> st.prog_err && st.prot_err)
        else $error("protected program not flagged");
    reset_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!st.loaded && !(cmd_valid && cmd_opcode == OP_SET_V)) |=> drive_strength == $past(st.drv_nv))
        else $error("working copy not loaded from NV copy");
    decode_default_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.loaded && drive_strength == DRV_DEFAULT) |-> drive_eighths == STR_50)
        else $error("default code not decoded as half strength");

    // Flag setting by operation kind, one cycle after op_done
    prog_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && (op_kind == FXR_OP_PAGE_PROG || op_kind == FXR_OP_INFO_PROG) && op_fail) |=> st.prog_err)
        else $error("failed program not flagged");
    info_prog_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_INFO_PROG && op_target_protected) |=> st.prog_err && st.prot_err)
        else $error("locked info row program not flagged");
    erase_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_ARRAY_ERASE && op_fail) |=> st.erase_err)
        else $error("failed erase not flagged");
    erase_protect_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_ARRAY_ERASE && op_target_protected) |=> st.erase_err && st.prot_err)
        else $error("protected erase not flagged");
    chip_erase_free_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_CHIP_ERASE && !(|block_protect_bits) && !op_fail && !op_target_protected
        && !st.erase_err) |=> !st.erase_err && !chip_erase_reject)
        else $error("unprotected chip erase flagged");
    nv_erase_phase_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_NV_REG_UPDATE && op_erase_phase_fail) |=> st.erase_err)
        else $error("NV update erase phase failure not flagged");
    nv_prog_phase_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_NV_REG_UPDATE && op_prog_phase_fail) |=> st.prog_err)
        else $error("NV update program phase failure not flagged");
    nv_update_noprot_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_NV_REG_UPDATE && !st.prot_err) |=> !st.prot_err)
        else $error("NV update raised protection flag");
    func_write_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_FUNC_WRITE && op_fail) |=> st.prog_err)
        else $error("failed function write not flagged");
    func_write_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_FUNC_WRITE && !op_fail && !st.prot_err && !st.prog_err && !st.erase_err)
        |=> !st.prot_err && !st.prog_err && !st.erase_err)
        else $error("ignored function write raised a flag");
    locked_status_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_STATUS_WRITE && status_write_lock && !wp_n_sync) |=> st.prot_err && st.erase_err)
        else $error("locked status write not flagged");
    open_status_a: assert property (@(posedge clk) disable iff (!arst_n)
        (op_done && op_kind == FXR_OP_STATUS_WRITE && !status_write_lock && !st.prot_err) |=> !st.prot_err)
        else $error("unlocked status write raised protection flag");
    ce_reject_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        chip_erase_reject |-> st.erase_err && st.prot_err)
        else $error("chip erase reject without flags");

    // Sticky flags and what may clear them
    erase_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.erase_err && !(cmd_valid && cmd_opcode == OP_CLEAR) && !soft_reset) |=> st.erase_err)
        else $error("erase flag dropped without clear");
    prot_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.prot_err && !(cmd_valid && cmd_opcode == OP_CLEAR) && !soft_reset) |=> st.prot_err)
        else $error("protection flag dropped without clear");
    soft_reset_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (soft_reset && !op_done) |=> !st.prot_err && !st.prog_err && !st.erase_err)
        else $error("soft reset did not drop flags");
    clear_keeps_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_CLEAR) |=> read_param_ext_status[BUSY_BIT] == $past(op_in_progress))
        else $error("clear disturbed busy bit");

    // Set commands and ignored write data
    set_nv_store_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_SET_NV) |=> st.drv_nv == $past(cmd_data[DRV_MSB:DRV_LSB]))
        else $error("NV copy not written");
    set_v_keeps_nv_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_SET_V) |=> $stable(st.drv_nv))
        else $error("volatile set touched NV copy");
    other_opcode_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.loaded && cmd_valid && cmd_opcode != OP_SET_NV && cmd_opcode != OP_SET_V) |=> $stable(st.drv_v)
        && $stable(st.drv_nv))
        else $error("other opcode changed drive copies");
    set_no_error_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_opcode == OP_SET_V && !op_done && !st.prog_err) |=> !st.prog_err)
        else $error("set command raised program flag");
    runs_with_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st.prog_err && cmd_valid && cmd_opcode == OP_SET_V) |=> drive_strength == $past(cmd_data[DRV_MSB:DRV_LSB]))
        else $error("command blocked by error flag");

    // Drive code decode, checked against the table rather than the decoder
    code_reserved_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength[1:0] == 2'h0) |-> drive_code_reserved && drive_eighths == STR_RSVD)
        else $error("reserved drive code not flagged");
    code_12p5_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength == 3'h1) |-> drive_eighths == STR_12P5)
        else $error("drive code 1 misdecoded");
    code_25_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength == 3'h2) |-> drive_eighths == STR_25)
        else $error("drive code 2 misdecoded");
    code_37p5_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength == 3'h3) |-> drive_eighths == STR_37P5)
        else $error("drive code 3 misdecoded");
    code_75_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength == 3'h5) |-> drive_eighths == STR_75)
        else $error("drive code 5 misdecoded");
    code_100_a: assert property (@(posedge clk) disable iff (!arst_n)
        (drive_strength == 3'h6) |-> drive_eighths == STR_100)
        else $error("drive code 6 misdecoded");

    cov_clear_c: cover property (@(posedge clk) disable iff (!arst_n) st.erase_err ##1 !st.erase_err);
    cov_nv_fail_c: cover property (@(posedge clk) disable iff (!arst_n)
        op_done && op_kind == FXR_OP_NV_REG_UPDATE && op_prog_phase_fail);
    cov_locked_sw_c: cover property (@(posedge clk) disable iff (!arst_n)
        op_done && op_kind == FXR_OP_STATUS_WRITE && status_write_lock && !wp_n_sync);
    cov_rsvd_code_c: cover property (@(posedge clk) disable iff (!arst_n) drive_code_reserved);
    // Refused chip erase seen at least once
    cov_ce_reject_c: cover property (@(posedge clk) disable iff (!arst_n) chip_erase_reject);
endmodule // fxr_ext_reg

// ==== fxr_host_model.sv ====
// Host controller model: issues decoded register commands to the block
`timescale 1ns/1ns
module fxr_host_model (
    input wire logic clk, // Clock
    output logic cmd_valid, // Command pulse
    output logic [7:0] cmd_opcode, // Opcode
    output logic [7:0] cmd_data // Data byte
);
    ////////////////////////////////////////////////////////////
    // Idle lines start quiet
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_data = 8'h00;
    end
    // One command for one edge; released lines show the inverse, never a stale value
    task automatic send(input logic [7:0] op, input logic [7:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_opcode <= op;
        cmd_data <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_opcode <= ~op;
        cmd_data <= ~data;
    endtask
endmodule // fxr_host_model

// ==== test_flash_ext_status_register.sv ====
// Self-checking testbench of the extended read-parameter register
`timescale 1ns/1ns
module test_flash_ext_status_register;
    import fxr_pkg::*;
    logic clk, arst_n, soft_reset, op_in_progress, op_done, op_fail, op_erase_phase_fail;
    logic op_prog_phase_fail, op_target_protected, status_write_lock, wp_n_pin;
    logic [3:0] block_protect_bits;
    fxr_op_t op_kind;
    logic cmd_valid;
    logic [7:0] cmd_opcode, cmd_data, read_param_ext_status;
    logic [2:0] drive_strength;
    logic [3:0] drive_eighths;
    logic drive_code_reserved, chip_erase_reject;
    int mismatches, checked, k;
    int str_tab[8] = '{0, 1, 2, 3, 0, 6, 8, 4};
    logic [2:0] drv;
    logic fe, fp, fr, bsy, rej;
    ////////////////////////////////////////////////////////////
    fxr_host_model hm (.clk(clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data));
    fxr_ext_reg dut (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .op_in_progress(op_in_progress), .op_done(op_done),
        .op_kind(op_kind), .op_fail(op_fail), .op_erase_phase_fail(op_erase_phase_fail),
        .op_prog_phase_fail(op_prog_phase_fail), .op_target_protected(op_target_protected),
        .block_protect_bits(block_protect_bits), .status_write_lock(status_write_lock), .wp_n_pin(wp_n_pin),
        .read_param_ext_status(read_param_ext_status), .drive_strength(drive_strength),
        .drive_eighths(drive_eighths), .drive_code_reserved(drive_code_reserved),
        .chip_erase_reject(chip_erase_reject));
    ////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare every visible output with the model; the reject pulse lasts one cycle only
    task automatic chk(input string what);
        checked++;
        if (read_param_ext_status !== {drv, 1'b1, fe, fp, fr, bsy} || drive_strength !== drv
            || chip_erase_reject !== rej || drive_eighths !== 4'(str_tab[drv])
            || drive_code_reserved !== (drv[1:0] == 2'b00)) begin
            mismatches++;
            $display("Error at %0t: %s read %h", $time, what, read_param_ext_status);
        end
        rej = 1'b0;
    endtask
    task automatic end_of_test();
        $display("Counts: %0d mismatches, %0d checked", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Finished operation from an engine, plus the flag model for each kind
    task automatic ev(input fxr_op_t kd, input logic f, input logic ef, input logic pf, input logic pt);
        @(posedge clk);
        op_done <= 1'b1;
        op_kind <= kd;
        op_fail <= f;
        op_erase_phase_fail <= ef;
        op_prog_phase_fail <= pf;
        op_target_protected <= pt;
        @(posedge clk);
        op_done <= 1'b0;
        case (kd)
            FXR_OP_PAGE_PROG, FXR_OP_INFO_PROG: begin
                fp |= f | pt;
                fr |= pt;
            end
            FXR_OP_ARRAY_ERASE: begin
                fe |= f | pt;
                fr |= pt;
            end
            FXR_OP_CHIP_ERASE: begin
                rej = |block_protect_bits;
                fe |= f | pt | rej;
                fr |= pt | rej;
            end
            FXR_OP_NV_REG_UPDATE: begin
                fe |= ef;
                fp |= pf;
            end
            FXR_OP_FUNC_WRITE: fp |= f;
            default: begin
                if (status_write_lock && !wp_n_pin) begin
                    fe = 1'b1;
                    fr = 1'b1;
                end else begin
                    fe |= ef;
                    fp |= pf;
                end
            end
        endcase
        #1 chk("operation");
    endtask
    task automatic clr();
        hm.send(OP_CLEAR, 8'($urandom));
        {fe, fp, fr} = 3'b000;
        #1 chk("clear");
    endtask
    task automatic setv(input logic [7:0] d);
        hm.send(OP_SET_V, d);
        drv = d[7:5];
        #1 chk("set volatile");
    endtask
    // Watchdog against a hang
    initial begin
        #(50 * 4000);
        mismatches++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {arst_n, soft_reset, op_in_progress, op_done, op_fail, op_erase_phase_fail} = 6'h00;
        {op_prog_phase_fail, op_target_protected, status_write_lock, block_protect_bits} = 7'h00;
        op_kind = FXR_OP_PAGE_PROG;
        wp_n_pin = 1'b1;
        {drv, fe, fp, fr, bsy, rej} = 8'he0;
        void'($urandom(39720));
        repeat (10) @(posedge clk);
        #1 chk("reset");
        arst_n <= 1'b1;
        for (k = 0; k < 8; k++) setv({k[2:0], 5'h1f});
        hm.send(8'h5a, 8'h00);
        #1 chk("unknown opcode");
        ev(FXR_OP_PAGE_PROG, 0, 0, 0, 1);
        clr();
        ev(FXR_OP_INFO_PROG, 1, 0, 0, 0);
        ev(FXR_OP_ARRAY_ERASE, 1, 0, 0, 0);
        setv(8'h1f);
        clr();
        block_protect_bits <= 4'h2;
        ev(FXR_OP_CHIP_ERASE, 0, 0, 0, 0);
        block_protect_bits <= 4'h0;
        ev(FXR_OP_NV_REG_UPDATE, 0, 1, 0, 0);
        clr();
        ev(FXR_OP_NV_REG_UPDATE, 0, 0, 1, 0);
        ev(FXR_OP_FUNC_WRITE, 1, 0, 0, 0);
        ev(FXR_OP_PAGE_PROG, 0, 0, 0, 0);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        {fe, fp, fr} = 3'b000;
        #1 chk("soft reset");
        hm.send(OP_SET_NV, 8'h60);
        #1 chk("set nonvolatile");
        // Locked status write only with the pin low, after the synchroniser settles
        for (k = 0; k < 2; k++) begin
            status_write_lock <= 1'b1;
            wp_n_pin <= k[0];
            repeat (4) @(posedge clk);
            ev(FXR_OP_STATUS_WRITE, 0, 0, 0, 0);
            clr();
        end
        status_write_lock <= 1'b0;
        wp_n_pin <= 1'b1;
        op_in_progress <= 1'b1;
        repeat (3) @(posedge clk);
        bsy = 1'b1;
        #1 chk("busy");
        setv(8'ha0);
        op_in_progress <= 1'b0;
        repeat (3) @(posedge clk);
        bsy = 1'b0;
        #1 chk("idle");
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        {drv, fe, fp, fr} = 6'h38;
        #1 chk("hardware reset");
        // Random mix of operations, set commands and clear commands
        repeat (80) begin
            k = $urandom % 10;
            block_protect_bits <= 4'($urandom);
            if (k < 7) begin
                @(posedge clk);
                ev(fxr_op_t'(k), $urandom & (k <= 3 || k == 5), $urandom & (k == 4 || k == 6),
                    $urandom & (k == 4 || k == 6),
                    $urandom & (k <= 3));
            end else if (k == 7) begin
                setv(8'($urandom));
            end else begin
                clr();
            end
        end
        end_of_test();
    end
endmodule // test_flash_ext_status_register
